// ### hw/tlr_top.sv
// What this block does
// - A running drive whose DC link falls below the trip level stops its output and flags low voltage.
// - A drop in supply while stopped never raises the low voltage trip.
// - The trip level is 1.414 x reference voltage x 65%, floored at 180 V or 350 V by class.
// - The low condition releases only once the DC link rises above 1.414 x reference x 80%.
// - In safety mode 0 the safety trip holds after the signal returns until a reset command.
// - In safety mode 1 the safety trip clears as soon as the safety signal is present again.
// - A reset request comes from the panel stop/reset key or from a function input terminal.
// - Any of the eight inputs set to function code 3 acts as trip reset.
// - A reset clears only latch-type trips and leaves other classes alone.
// - With several latch trips active, reset clears them only when all release conditions hold.
// - Software error, watchdog and memory error trips are fatal and never reset by command.
// - The external block trip follows its input level.
// - The arm short trip latches until a valid reset.
module tlr_top (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  input  wire logic [tlr_pkg::VOLT_W-1:0]   dc_link_volt,
  input  wire logic                         drive_running,
  input  wire logic                         sw_error,
  input  wire logic                         watchdog_trip,
  input  wire logic                         memory_error,
  input  wire logic                         safety_ok,
  input  wire logic                         external_block_input,
  input  wire logic                         arm_short,
  input  wire logic                         panel_reset_key,
  input  wire logic [tlr_pkg::NUM_DI-1:0]   di_pins,
  output logic                              output_stop,
  output logic                              trip_active,
  output logic [tlr_pkg::NUM_DO-1:0]        do_pins,
  output logic                              irq
);
  // ----------------------------------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  localparam int NPIN = tlr_pkg::NUM_DI + 4;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_q;

  // Asynchronous pins pass two flops; only the second stage is ever read.
  // The safety input idles high, so its stages reset high and no false trip follows reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= {{(NPIN-1){1'b0}}, 1'b1};
      pin_q      <= {{(NPIN-1){1'b0}}, 1'b1};
    end else begin
      pin_meta_q <= {di_pins, panel_reset_key, arm_short, external_block_input, safety_ok};
      pin_q      <= pin_meta_q;
    end
  end

  logic                      safe_ok_s;
  logic                      block_s;
  logic                      arm_s;
  logic                      key_s;
  logic [tlr_pkg::NUM_DI-1:0] di_s;
  assign safe_ok_s = pin_q[0];
  assign block_s   = pin_q[1];
  assign arm_s     = pin_q[2];
  assign key_s     = pin_q[3];
  assign di_s      = pin_q[NPIN-1:4];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]                  ctrl_q;
  logic [tlr_pkg::REFV_W-1:0]  refv_q;
  logic [31:0]                 difn_q;
  logic [17:0]                 dofn_q;
  logic [tlr_pkg::NUM_EV-1:0]  irq_en_q;
  logic [tlr_pkg::NUM_EV-1:0]  irq_st_q;
  logic [7:0]                  addr_q;
  logic                        wr_q;
  logic                        rd_q;
  logic                        sw_reset;
  logic [tlr_pkg::NUM_EV-1:0]  irq_clr;

  wire logic acc = hsel && htrans[1] && hready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      wr_q <= acc && hwrite;
      rd_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= tlr_pkg::CTRL_RST;
      refv_q   <= tlr_pkg::REFV_RST;
      difn_q   <= tlr_pkg::DIFN_RST;
      dofn_q   <= tlr_pkg::DOFN_RST;
      irq_en_q <= '0;
    end else if (wr_q) begin
      if (wr_hit(addr_q, tlr_pkg::CTRL_OFS)) ctrl_q <= hwdata[2:0];
      if (wr_hit(addr_q, tlr_pkg::REFV_OFS)) refv_q <= hwdata[tlr_pkg::REFV_W-1:0];
      if (wr_hit(addr_q, tlr_pkg::DIFN_OFS)) difn_q <= hwdata;
      if (wr_hit(addr_q, tlr_pkg::DOFN_OFS)) dofn_q <= hwdata[17:0];
      if (wr_hit(addr_q, tlr_pkg::IRQ_EN_OFS)) irq_en_q <= hwdata[tlr_pkg::NUM_EV-1:0];
    end
  end

  assign sw_reset = wr_q && wr_hit(addr_q, tlr_pkg::CMD_OFS) && hwdata[tlr_pkg::CMD_RESET];
  assign irq_clr  = (wr_q && wr_hit(addr_q, tlr_pkg::IRQ_CLR_OFS)) ?
                    hwdata[tlr_pkg::NUM_EV-1:0] : '0;

  // ----------------------------------------------------------------
  // Undervoltage detector
  // ----------------------------------------------------------------
  tlr_uv_if uvb ();
  assign uvb.ref_volt  = refv_q;
  assign uvb.class_400 = ctrl_q[tlr_pkg::CTRL_CLASS];
  assign uvb.dc_volt   = dc_link_volt;
  assign uvb.running   = drive_running;

  tlr_uv_detect u_uv (
    .clk   (clk),
    .rst_n (rst_n),
    .uv    (uvb)
  );

  // ----------------------------------------------------------------
  // Reset command
  // ----------------------------------------------------------------
  logic [tlr_pkg::NUM_DI-1:0] di_rst_sel;
  logic                       rst_src;
  logic                       rst_src_q;
  logic                       reset_req;

  always_comb begin
    for (int i = 0; i < tlr_pkg::NUM_DI; i++) begin
      di_rst_sel[i] = difn_q[i*tlr_pkg::DI_FN_W +: tlr_pkg::DI_FN_W] == tlr_pkg::DI_FN_RESET;
    end
  end

  assign rst_src = key_s || |(di_s & di_rst_sel);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_src_q <= 1'b0;
    end else begin
      rst_src_q <= rst_src;
    end
  end

  // A held key or terminal counts once; software can also issue one.
  assign reset_req = (rst_src && !rst_src_q) || sw_reset;

  // ----------------------------------------------------------------
  // Trip state
  // ----------------------------------------------------------------
  logic uv_mode_lvl;
  logic safe_mode_lvl;
  logic uv_lat_q;
  logic safe_lat_q;
  logic arm_lat_q;
  logic fatal_q;
  logic uv_trip;
  logic safe_trip;
  logic release_ok;
  logic do_release;
  logic any_latch;

  assign uv_mode_lvl   = ctrl_q[tlr_pkg::CTRL_UV_MODE];
  assign safe_mode_lvl = ctrl_q[tlr_pkg::CTRL_SAFE_MODE];

  // Every active latch trip must be able to release, otherwise none does.
  assign release_ok = !uvb.uv_cond && safe_ok_s && !arm_s;
  assign any_latch  = uv_lat_q || safe_lat_q || arm_lat_q;
  assign do_release = reset_req && release_ok && any_latch;

  // A new event in the release cycle wins over the release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_lat_q   <= 1'b0;
      safe_lat_q <= 1'b0;
      arm_lat_q  <= 1'b0;
    end else begin
      uv_lat_q   <= (!uv_mode_lvl && uvb.uv_cond) || (uv_lat_q && !do_release && !uv_mode_lvl);
      safe_lat_q <= (!safe_mode_lvl && !safe_ok_s) ||
                    (safe_lat_q && !do_release && !safe_mode_lvl);
      arm_lat_q  <= arm_s || (arm_lat_q && !do_release);
    end
  end

  // Fatal trips ignore every reset command; only power-on reset clears them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fatal_q <= 1'b0;
    end else if (sw_error || watchdog_trip || memory_error) begin
      fatal_q <= 1'b1;
    end
  end

  assign uv_trip   = uv_mode_lvl ? uvb.uv_cond : uv_lat_q;
  assign safe_trip = safe_mode_lvl ? !safe_ok_s : safe_lat_q;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [4:0] trips;
  logic [4:0] trips_q;
  assign trips = {block_s, fatal_q, arm_lat_q, safe_trip, uv_trip};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trips_q     <= '0;
      output_stop <= 1'b0;
      trip_active <= 1'b0;
      do_pins     <= '0;
    end else begin
      trips_q     <= trips;
      output_stop <= |trips;
      trip_active <= |trips;
      for (int i = 0; i < tlr_pkg::NUM_DO; i++) begin
        do_pins[i] <= uv_trip &&
                      dofn_q[i*tlr_pkg::DO_FN_W +: tlr_pkg::DO_FN_W] == tlr_pkg::DO_FN_UV;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [tlr_pkg::NUM_EV-1:0] ev;
  assign ev = {do_release, trips & ~trips_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_q <= ev | (irq_st_q & ~irq_clr);
      irq      <= |((ev | (irq_st_q & ~irq_clr)) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Bus read side
  // ----------------------------------------------------------------
  // Zero wait states: the read mux looks at live flops in the data phase.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_q) begin
      unique case (addr_q)
        tlr_pkg::CTRL_OFS:   hrdata = {29'h0, ctrl_q};
        tlr_pkg::REFV_OFS:   hrdata = {23'h0, refv_q};
        tlr_pkg::DIFN_OFS:   hrdata = difn_q;
        tlr_pkg::DOFN_OFS:   hrdata = {14'h0, dofn_q};
        tlr_pkg::STAT_OFS:   hrdata = {26'h0, drive_running, trips};
        tlr_pkg::IRQ_ST_OFS: hrdata = {26'h0, irq_st_q};
        tlr_pkg::IRQ_EN_OFS: hrdata = {26'h0, irq_en_q};
        tlr_pkg::THR_OFS:    hrdata = {6'h0, uvb.rel_lvl, 6'h0, uvb.trip_lvl};
        default:             hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_follows_uv_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_trip |=> output_stop)
    else $error("Output not stopped on low voltage.");
  safe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    safe_lat_q && !safe_mode_lvl && !reset_req && $stable(ctrl_q) |=> safe_lat_q)
    else $error("Latched safety trip dropped without reset.");
  safe_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    safe_mode_lvl && safe_ok_s |-> !safe_trip)
    else $error("Level safety trip held with signal present.");
  di_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(di_s[0]) && di_rst_sel[0] && !rst_src_q |-> reset_req)
    else $error("Reset terminal ignored.");
  fatal_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    fatal_q |=> fatal_q)
    else $error("Fatal trip cleared by command.");
  block_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    block_s |=> trip_active)
    else $error("Block input did not trip.");
  arm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    arm_lat_q && !reset_req |=> arm_lat_q)
    else $error("Arm short trip lost without reset.");
  all_or_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    reset_req && arm_lat_q && !release_ok |=> arm_lat_q)
    else $error("Latch trip released with a condition still pending.");
  uv_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_trip && dofn_q[5:0] == tlr_pkg::DO_FN_UV && $stable(dofn_q) |=> do_pins[0])
    else $error("Low voltage output not driven.");
  lat_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    uv_lat_q && !uv_mode_lvl && !reset_req && $stable(ctrl_q) |=> uv_lat_q)
    else $error("Latched low voltage dropped without reset.");

  uv_trip_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(uv_trip));
  release_c: cover property (@(posedge clk) disable iff (!rst_n) do_release);
  safe_lvl_c: cover property (@(posedge clk) disable iff (!rst_n)
    safe_mode_lvl && $fell(safe_trip));
  irq_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

// ### include/tlr_pkg.sv
package tlr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] REFV_OFS    = 8'h04;
  localparam logic [7:0] DIFN_OFS    = 8'h08;
  localparam logic [7:0] DOFN_OFS    = 8'h0C;
  localparam logic [7:0] STAT_OFS    = 8'h10;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS  = 8'h1C;
  localparam logic [7:0] THR_OFS     = 8'h20;
  localparam logic [7:0] CMD_OFS     = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_UV_MODE   = 0;
  localparam int CTRL_SAFE_MODE = 1;
  localparam int CTRL_CLASS     = 2;
  localparam int CMD_RESET      = 0;
  localparam int ST_UV          = 0;
  localparam int ST_SAFE        = 1;
  localparam int ST_ARM         = 2;
  localparam int ST_FATAL       = 3;
  localparam int ST_BLOCK       = 4;
  localparam int ST_RUN         = 5;
  localparam int EV_UV          = 0;
  localparam int EV_SAFE        = 1;
  localparam int EV_ARM         = 2;
  localparam int EV_FATAL       = 3;
  localparam int EV_BLOCK       = 4;
  localparam int EV_RESET       = 5;
  localparam int NUM_EV         = 6;
  localparam int NUM_DI         = 8;
  localparam int NUM_DO         = 3;
  localparam int DI_FN_W        = 4;
  localparam int DO_FN_W        = 6;
  localparam int VOLT_W         = 10;
  localparam int REFV_W         = 9;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0]          CTRL_RST    = 3'h0;
  localparam logic [REFV_W-1:0]   REFV_RST    = 9'h0DC;
  localparam logic [31:0]         DIFN_RST    = 32'h0000_0000;
  localparam logic [17:0]         DOFN_RST    = 18'h00000;
  localparam logic [DI_FN_W-1:0]  DI_FN_RESET = 4'h3;
  localparam logic [DO_FN_W-1:0]  DO_FN_UV    = 6'h0B;
  // ----------------------------------------------------------------
  // Threshold arithmetic
  // ----------------------------------------------------------------
  localparam int SQRT2_MILLI = 1414;
  localparam int TRIP_PCT    = 65;
  localparam int REL_PCT     = 80;
  localparam int SCALE_DIV   = 100000;
  localparam logic [VOLT_W-1:0] MIN_TRIP_200 = 10'd180;
  localparam logic [VOLT_W-1:0] MIN_TRIP_400 = 10'd350;
  // ----------------------------------------------------------------
  // Undervoltage condition states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {UV_OK, UV_LOW} tlr_uv_state_t;
endpackage

// ### include/tlr_uv_if.sv
interface tlr_uv_if;
  logic [tlr_pkg::REFV_W-1:0] ref_volt;
  logic                       class_400;
  logic [tlr_pkg::VOLT_W-1:0] dc_volt;
  logic                       running;
  logic                       uv_cond;
  logic [tlr_pkg::VOLT_W-1:0] trip_lvl;
  logic [tlr_pkg::VOLT_W-1:0] rel_lvl;
  modport ctl (output ref_volt, output class_400, output dc_volt, output running,
               input uv_cond, input trip_lvl, input rel_lvl);
  modport det (input ref_volt, input class_400, input dc_volt, input running,
               output uv_cond, output trip_lvl, output rel_lvl);
endinterface

// ### hw/tlr_uv_detect.sv
module tlr_uv_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  tlr_uv_if.det     uv
);
  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  function automatic logic [tlr_pkg::VOLT_W-1:0] scale(input logic [tlr_pkg::REFV_W-1:0] v,
                                                       input int pct);
    logic [31:0] p;
    p = 32'(v) * 32'(tlr_pkg::SQRT2_MILLI) * 32'(pct) / 32'(tlr_pkg::SCALE_DIV);
    return p[tlr_pkg::VOLT_W-1:0];
  endfunction

  logic [tlr_pkg::VOLT_W-1:0] raw_trip;
  logic [tlr_pkg::VOLT_W-1:0] min_trip;
  logic [tlr_pkg::VOLT_W-1:0] trip_q;
  logic [tlr_pkg::VOLT_W-1:0] rel_q;
  tlr_pkg::tlr_uv_state_t     st_q;

  assign raw_trip = scale(uv.ref_volt, tlr_pkg::TRIP_PCT);
  assign min_trip = uv.class_400 ? tlr_pkg::MIN_TRIP_400 : tlr_pkg::MIN_TRIP_200;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_q <= '0;
      rel_q  <= '0;
    end else begin
      trip_q <= (raw_trip < min_trip) ? min_trip : raw_trip;
      rel_q  <= scale(uv.ref_volt, tlr_pkg::REL_PCT);
    end
  end

  // ----------------------------------------------------------------
  // Hysteresis
  // ----------------------------------------------------------------
  // A stopped drive never enters the low state, so a normal power-down does not trip.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= tlr_pkg::UV_OK;
    end else begin
      unique case (st_q)
        tlr_pkg::UV_OK:  if (uv.running && uv.dc_volt < trip_q) st_q <= tlr_pkg::UV_LOW;
        tlr_pkg::UV_LOW: if (uv.dc_volt > rel_q) st_q <= tlr_pkg::UV_OK;
      endcase
    end
  end

  assign uv.uv_cond  = (st_q == tlr_pkg::UV_LOW);
  assign uv.trip_lvl = trip_q;
  assign uv.rel_lvl  = rel_q;

  uv_no_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !uv.running && st_q == tlr_pkg::UV_OK |=> st_q == tlr_pkg::UV_OK)
    else $error("Undervoltage entered while stopped.");
  uv_hyst_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == tlr_pkg::UV_LOW && uv.dc_volt <= rel_q |=> st_q == tlr_pkg::UV_LOW)
    else $error("Undervoltage released below release level.");
  uv_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(uv.ref_volt) && $stable(uv.class_400) |=> trip_q >= $past(min_trip))
    else $error("Trip level below class floor.");
endmodule

// ### verification/tlr_far_side.sv
module tlr_far_side (
  input  wire logic       clk,
  input  wire logic       safe_c,
  input  wire logic       blk_c,
  input  wire logic       arm_c,
  input  wire logic       key_c,
  input  wire logic [7:0] di_c,
  output logic            safety_ok,
  output logic            external_block_input,
  output logic            arm_short,
  output logic            panel_reset_key,
  output logic [7:0]      di_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Terminal board, safety input and panel key
  // ----------------------------------------------------------------
  // Pins move only after a clock edge, so the design never sees a level change mid-cycle.
  initial begin
    {safety_ok, external_block_input, arm_short, panel_reset_key, di_pins} = 12'h800;
  end
  always @(posedge clk) begin
    safety_ok <= safe_c;
    external_block_input <= blk_c;
    arm_short <= arm_c;
    panel_reset_key <= key_c;
    di_pins <= di_c;
  end
endmodule

// ### verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, hsel, hwrite, run, swe, wdt, mem, s_c, b_c, a_c, k_c;
  logic        hrdy, hresp, stop, trip, irq, sok, blk, arm, key;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [9:0]  dc;
  logic [7:0]  di_c, di;
  logic [2:0]  dop;
  int          bad_count, checks;
  tlr_top tlr_top_inst (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .dc_link_volt(dc), .drive_running(run), .sw_error(swe),
    .watchdog_trip(wdt), .memory_error(mem), .safety_ok(sok), .external_block_input(blk),
    .arm_short(arm), .panel_reset_key(key), .di_pins(di), .output_stop(stop),
    .trip_active(trip), .do_pins(dop), .irq(irq));
  tlr_far_side tlr_far_side_inst (.clk(clk), .safe_c(s_c), .blk_c(b_c), .arm_c(a_c),
    .key_c(k_c), .di_c(di_c), .safety_ok(sok), .external_block_input(blk), .arm_short(arm),
    .panel_reset_key(key), .di_pins(di));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task test_done;
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        $display("[ERR] %0t bus wait ran out", $time);
        test_done;
      end
      @(posedge clk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    rdy;
    r = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask
  // Fixed settle time covers sync, latch and output flops with margin.
  task stat(input logic [31:0] e);
    repeat (8) @(posedge clk);
    bus(1'b0, tlr_pkg::STAT_OFS, 32'h0);
    cmp(r & 32'h3F, e);
    cmp({31'h0, stop}, {31'h0, |e[4:0]});
    cmp({31'h0, trip}, {31'h0, |e[4:0]});
  endtask
  task dreset;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_uv;
    bus(1'b0, tlr_pkg::REFV_OFS, 32'h0); cmp(r, 32'h0000_00DC);
    bus(1'b0, 8'hFC, 32'h0); cmp(r, 32'h0);
    bus(1'b1, tlr_pkg::DOFN_OFS, 32'h0000_000B);
    bus(1'b0, tlr_pkg::THR_OFS, 32'h0); cmp(r, {6'h0, 10'd248, 6'h0, 10'd202});
    run <= 1'b1; dc <= 10'd201; stat(32'h21); cmp({29'h0, dop}, 32'h1);
    dc <= 10'd230; bus(1'b1, tlr_pkg::CMD_OFS, 32'h1); stat(32'h21);
    dc <= 10'd249; bus(1'b1, tlr_pkg::CMD_OFS, 32'h1); stat(32'h20);
    run <= 1'b0; dc <= 10'd100; stat(32'h0); dc <= 10'd249;
    bus(1'b1, tlr_pkg::CTRL_OFS, 32'h1); run <= 1'b1; dc <= 10'd150; stat(32'h21);
    dc <= 10'd249; stat(32'h20);
    bus(1'b1, tlr_pkg::REFV_OFS, 32'd100);
    bus(1'b0, tlr_pkg::THR_OFS, 32'h0); cmp(r, {6'h0, 10'd113, 6'h0, 10'd180});
    run <= 1'b0; bus(1'b1, tlr_pkg::CTRL_OFS, 32'h4);
    bus(1'b0, tlr_pkg::THR_OFS, 32'h0); cmp(r, {6'h0, 10'd113, 6'h0, 10'd350});
    bus(1'b1, tlr_pkg::CTRL_OFS, 32'h0); bus(1'b1, tlr_pkg::REFV_OFS, 32'd220);
    run <= 1'b1;
  endtask
  task s_safe;
    bus(1'b1, tlr_pkg::DIFN_OFS, 32'h0000_0003);
    s_c <= 1'b0; stat(32'h22); s_c <= 1'b1; stat(32'h22);
    di_c <= 8'h01; stat(32'h20); di_c <= 8'h00;
    bus(1'b1, tlr_pkg::CTRL_OFS, 32'h2); s_c <= 1'b0; stat(32'h22);
    s_c <= 1'b1; stat(32'h20); bus(1'b1, tlr_pkg::CTRL_OFS, 32'h0);
  endtask
  task s_arm;
    bus(1'b1, tlr_pkg::DIFN_OFS, 32'h3000_0000);
    a_c <= 1'b1; s_c <= 1'b0; stat(32'h26); s_c <= 1'b1;
    k_c <= 1'b1; stat(32'h26); k_c <= 1'b0;
    a_c <= 1'b0; di_c <= 8'h01; stat(32'h26);
    di_c <= 8'h80; stat(32'h20); di_c <= 8'h00;
    a_c <= 1'b1; repeat (4) @(posedge clk); a_c <= 1'b0; stat(32'h24);
    k_c <= 1'b1; stat(32'h20); k_c <= 1'b0;
  endtask
  task s_blk;
    bus(1'b1, tlr_pkg::IRQ_CLR_OFS, 32'h3F); bus(1'b1, tlr_pkg::IRQ_EN_OFS, 32'h0);
    b_c <= 1'b1; stat(32'h30); cmp({31'h0, irq}, 32'h0);
    bus(1'b1, tlr_pkg::CMD_OFS, 32'h1); stat(32'h30);
    b_c <= 1'b0; stat(32'h20);
    bus(1'b1, tlr_pkg::IRQ_EN_OFS, 32'h10); repeat (2) @(posedge clk); cmp({31'h0, irq}, 32'h1);
    bus(1'b0, tlr_pkg::IRQ_ST_OFS, 32'h0); cmp(r & 32'h10, 32'h10);
    bus(1'b1, tlr_pkg::IRQ_CLR_OFS, 32'h10); repeat (2) @(posedge clk); cmp({31'h0, irq}, 32'h0);
  endtask
  task s_fatal;
    for (int i = 0; i < 3; i++) begin
      {mem, wdt, swe} <= 3'h1 << i; stat(32'h28); {mem, wdt, swe} <= 3'h0;
      bus(1'b1, tlr_pkg::CMD_OFS, 32'h1); stat(32'h28); dreset; stat(32'h20);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rstn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    run = 1'b0; dc = 10'd249; {swe, wdt, mem, b_c, a_c, k_c} = 6'h00; s_c = 1'b1; di_c = 8'h00;
    bad_count = 0; checks = 0;
    dreset;
    s_uv;
    s_safe;
    s_arm;
    s_blk;
    s_fatal;
    test_done;
  end
endmodule
